//--- odec_pkg.sv
// Notes on behaviour
// - Accumulator select picks exactly one of A or B as DSP target.
// - Write-back target is W13 direct or [W13] with W13 post-incremented by 2.
// - Bit selector is 4 bits, positions 0 to 15 of the word.
// - File-register address field covers 0 to 0x1FFF.
// - Unsigned 10-bit literal: 0..255 in byte size, 0..1023 in word size.
// - 23-bit program address literal must have its LSB at zero.
// - Unsigned literals of 1, 4, 5, 8, 14, 16 bits are zero-extended.
// - Signed literals of 6, 10, 16 bits are sign-extended.
// - Square operand pair uses one of W4..W7 for both factors.
// - Multiply pair is one of six distinct pairs from W4..W7.
// - X prefetch: W8/W9 with 0,+-2,+-4,+-6; or [W9+W12]; or none.
// - Y prefetch: W10/W11 with 0,+-2,+-4,+-6; or [W11+W12]; or none.
// - Prefetched X and Y data go to one of W4..W7.
// - Register fields select one of sixteen working registers W0..W15.
// - File result aimed at the default working register goes to W0.
// - Operand size is byte, word or double-word; word when not encoded.
// - DSP source: direct, indirect, pre/post inc/dec, base-register offset.
// - Divide takes dividend and divisor from directly addressed registers.
// - Five general status bits: carry, half carry, negative, wrap, zero.
// - Per-accumulator overflow and clip status bits.
// - Instruction is 24 bits with an 8-bit leading opcode.
package odec_pkg;
	// Instruction word shape
	localparam int unsigned INSN_W = 24;
	localparam int unsigned OPC_W  = 8;
	localparam int unsigned LIT_W  = 24;
	// Operand class in the top nibble of the opcode
	localparam logic [3:0] CLS_FILE  = 4'h1;
	localparam logic [3:0] CLS_BIT   = 4'h2;
	localparam logic [3:0] CLS_LIT10 = 4'h3;
	localparam logic [3:0] CLS_DEFAULT_WORKING_REG  = 4'h4;
	localparam logic [3:0] CLS_MAC   = 4'h5;
	localparam logic [3:0] CLS_SQR   = 4'h6;
	localparam logic [3:0] CLS_LITK  = 4'h7;
	localparam logic [3:0] CLS_PROG  = 4'h8;
	localparam logic [3:0] CLS_DIV   = 4'h9;
	localparam logic [3:0] CLS_DSRC  = 4'ha;
	// Operand sizes
	localparam logic [1:0] SZ_WORD  = 2'h0;
	localparam logic [1:0] SZ_BYTE  = 2'h1;
	localparam logic [1:0] SZ_DWORD = 2'h2;
	localparam logic [1:0] SZ_BAD   = 2'h3;
	// Register addressing modes
	localparam logic [2:0] M_DIR  = 3'h0;
	localparam logic [2:0] M_IND  = 3'h1;
	localparam logic [2:0] M_PINC = 3'h2;
	localparam logic [2:0] M_PDEC = 3'h3;
	localparam logic [2:0] M_INCP = 3'h4;
	localparam logic [2:0] M_DECP = 3'h5;
	localparam logic [2:0] M_OFFS = 3'h6;
	// Fixed registers
	localparam logic [3:0] REG_W0  = 4'h0;
	localparam logic [3:0] REG_W4  = 4'h4;
	localparam logic [3:0] REG_W8  = 4'h8;
	localparam logic [3:0] REG_W10 = 4'ha;
	localparam logic [3:0] REG_W13 = 4'hd;
	localparam logic [1:0] AWB_NONE = 2'h0;
	localparam logic [1:0] AWB_REG  = 2'h1;
	localparam logic [1:0] AWB_POST = 2'h2;
	localparam logic [7:0] BYTE_MAX = 8'hff;
	// Status flag bit positions
	localparam int unsigned FLB_CARRY = 0;
	localparam int unsigned FLB_HALF  = 1;
	localparam int unsigned FLB_NEG   = 2;
	localparam int unsigned FLB_WRAP  = 3;
	localparam int unsigned FLB_ZERO  = 4;
	localparam int unsigned FLB_OVA   = 5;
	localparam int unsigned FLB_OVB   = 6;
	localparam int unsigned FLB_CLA   = 7;
	localparam int unsigned FLB_CLB   = 8;
	localparam int unsigned FLAG_W    = 9;
	// APB register map
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_STAT  = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_FLAGS = 8'h0c;
	localparam int unsigned CTRL_EN  = 0;
	localparam int unsigned CTRL_SQ  = 1;
	localparam logic [1:0] CTRL_RST  = 2'h1;
	localparam int unsigned STAT_ILL = 0;

	// Zero or sign extension of a low field of w bits
	function automatic logic [LIT_W-1:0] odec_ext(input logic [15:0] raw, input logic [4:0] w,
		input logic sgn);
		logic [LIT_W-1:0] r;
		logic             top;
		r   = '0;
		top = sgn & raw[4'(w - 5'd1)];
		for (int i = 0; i < LIT_W; i++) begin
			if (i < 16 && i < int'(w)) begin
				r[i] = raw[i[3:0]];
			end else begin
				r[i] = top;
			end
		end
		return r;
	endfunction

	// Register modes allowed for plain source and destination fields
	function automatic logic odec_mode_ok(input logic [2:0] m);
		return m <= M_DECP;
	endfunction
endpackage

//--- odec_fetch_if.sv
`timescale 1ns/1ps
`default_nettype none
interface odec_fetch_if;
	logic       [3:0] code;  // Raw prefetch field
	logic             en;    // Prefetch wanted
	logic       [3:0] ptr;   // Pointer register
	logic signed [3:0] adj;  // Post-adjustment in bytes
	logic             idx;   // Pointer offset by W12
	modport dec (input code, output en, ptr, adj, idx);
	modport use_side (output code, input en, ptr, adj, idx);
endinterface
`default_nettype wire

//--- odec_fetch_dec.sv
`timescale 1ns/1ps
`default_nettype none
module odec_fetch_dec
	import odec_pkg::*;
#(
	parameter logic [3:0] PTR0 = REG_W8  // First of the two pointer registers
) (
	odec_fetch_if.dec f  // Code in, decoded fetch out
);
	logic [2:0] step;

	// Codes 0..6 use PTR0, 7..13 the next register, 14 indexed, 15 none
	always_comb begin
		step  = 3'h0;
		f.en  = 1'b1;
		f.idx = 1'b0;
		f.ptr = PTR0;
		f.adj = 4'sh0;
		if (f.code == 4'hf) begin
			f.en = 1'b0;
		end else if (f.code == 4'he) begin
			f.ptr = PTR0 + 4'h1;
			f.idx = 1'b1;
		end else begin
			step = (f.code >= 4'h7) ? 3'(f.code - 4'h7) : f.code[2:0];
			f.ptr = (f.code >= 4'h7) ? PTR0 + 4'h1 : PTR0;
			case (step)
				3'h0: f.adj = 4'sh6;
				3'h1: f.adj = 4'sh4;
				3'h2: f.adj = 4'sh2;
				3'h3: f.adj = 4'sh0;
				3'h4: f.adj = -4'sh6;
				3'h5: f.adj = -4'sh4;
				default: f.adj = -4'sh2;
			endcase
		end
	end
endmodule // odec_fetch_dec
`default_nettype wire

//--- odec_core.sv
`timescale 1ns/1ps
`default_nettype none
module odec_core
	import odec_pkg::*;
#(
	parameter int unsigned CNT_W = 16  // Width of the decode counter
) (
	input  wire logic                pclk,          // Core clock
	input  wire logic                presetn,       // Async reset, active low
	input  wire logic [7:0]          paddr,         // APB address
	input  wire logic                psel,          // APB select
	input  wire logic                penable,       // APB access phase
	input  wire logic                pwrite,        // APB write
	input  wire logic [31:0]         pwdata,        // APB write data
	output logic      [31:0]         prdata,        // APB read data
	output logic                     pready,        // APB ready
	output logic                     pslverr,       // APB error
	input  wire logic                insn_valid,    // Fetch word valid
	input  wire logic [INSN_W-1:0]   insn_word,     // Fetched word
	input  wire logic [FLAG_W-1:0]   flag_we,       // Datapath flag write enables
	input  wire logic [FLAG_W-1:0]   flag_wd,       // Datapath flag values
	output logic                     dec_valid,     // Decoded word present
	output logic                     dec_illegal,   // Out-of-set operand
	output logic      [OPC_W-1:0]    dec_opcode,    // Leading opcode
	output logic      [3:0]          dec_class,     // Operand class
	output logic      [1:0]          dec_size,      // Operand size
	output logic                     acc_sel,       // 0 = A, 1 = B
	output logic      [1:0]          awb_sel,       // Write-back target
	output logic      [3:0]          base_reg,      // Base register
	output logic      [3:0]          src_reg,       // Source register
	output logic      [2:0]          src_mode,      // Source mode
	output logic      [3:0]          dst_reg,       // Destination register
	output logic      [2:0]          dst_mode,      // Destination mode
	output logic                     dst_default_working_reg,      // Result to W0
	output logic      [12:0]         file_addr,     // File register address
	output logic      [3:0]          bit_pos,       // Bit selector
	output logic      [LIT_W-1:0]    lit_value,     // Extended literal
	output logic      [3:0]          mul_a,         // Multiplicand register
	output logic      [3:0]          mul_b,         // Multiplier register
	output logic                     x_en,          // X prefetch wanted
	output logic      [3:0]          x_ptr,         // X pointer
	output logic signed [3:0]        x_adj,         // X post-adjust
	output logic                     x_idx,         // X indexed by W12
	output logic      [3:0]          x_dst,         // X prefetch target
	output logic                     y_en,          // Y prefetch wanted
	output logic      [3:0]          y_ptr,         // Y pointer
	output logic signed [3:0]        y_adj,         // Y post-adjust
	output logic                     y_idx,         // Y indexed by W12
	output logic      [3:0]          y_dst,         // Y prefetch target
	output logic      [FLAG_W-1:0]   status_flags   // Status bits
);
	if (CNT_W < 1 || CNT_W > 32) begin : g_chk
		$error("CNT_W must be 1 to 32");
	end

	typedef struct packed {
		logic [OPC_W-1:0]  opcode;
		logic [3:0]        cls;
		logic [1:0]        size;
		logic              illegal;
		logic              acc;
		logic [1:0]        result_writeback_target;
		logic [3:0]        base;
		logic [3:0]        src;
		logic [2:0]        src_m;
		logic [3:0]        dst;
		logic [2:0]        dst_m;
		logic              dst_w;
		logic [12:0]       faddr;
		logic [3:0]        bpos;
		logic [LIT_W-1:0]  lit;
		logic [3:0]        ma;
		logic [3:0]        mb;
		logic              xen;
		logic [3:0]        xptr;
		logic [3:0]        xadj;
		logic              xidx;
		logic [3:0]        xdst;
		logic              yen;
		logic [3:0]        yptr;
		logic [3:0]        yadj;
		logic              yidx;
		logic [3:0]        ydst;
	} odec_dec_s;

	typedef enum logic {ST_ONE, ST_ADDR_LO} odec_st_e;

	odec_st_e          st_q;
	odec_dec_s         d;
	odec_dec_s         dec_q;
	logic              dec_valid_q;
	logic [6:0]        hi_q;
	logic [OPC_W-1:0]  hi_op_q;
	logic [1:0]        ctrl_q;
	logic              ill_seen_q;
	logic [CNT_W-1:0]  cnt_q;
	logic [FLAG_W-1:0] flags_q;
	logic              ready_q;
	logic              err_q;
	logic [31:0]       rdata_q;
	logic [31:0]       rd;
	logic              hit;
	logic              take;
	logic              first_prog;
	logic              issue;
	logic              wr_fire;
	logic [2:0]        pair;
	logic [INSN_W-1:0] w;

	odec_fetch_if xif ();
	odec_fetch_if yif ();

	assign w        = insn_word;
	assign xif.code = w[15:12];
	assign yif.code = w[11:8];

	odec_fetch_dec #(.PTR0(REG_W8)) u_xdec (
		.f (xif)
	);

	odec_fetch_dec #(.PTR0(REG_W10)) u_ydec (
		.f (yif)
	);

	////////////////////////////////////////////////////////////////////////
	// Word acceptance
	////////////////////////////////////////////////////////////////////////

	// Program-address class holds its word back until the low half arrives
	assign take       = insn_valid & ctrl_q[CTRL_EN];
	assign first_prog = (st_q == ST_ONE) && (w[23:20] == CLS_PROG);
	assign issue      = take & ~first_prog;
	assign pair       = w[18:16];

	// Two-word tracker
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q    <= ST_ONE;
			hi_q    <= 7'h00;
			hi_op_q <= 8'h00;
		end else if (take) begin
			case (st_q)
				ST_ONE: begin
					if (first_prog) begin
						st_q    <= ST_ADDR_LO;
						hi_q    <= w[6:0];
						hi_op_q <= w[23:16];
					end
				end
				ST_ADDR_LO: st_q <= ST_ONE;
				default: st_q <= ST_ONE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Operand field decode
	////////////////////////////////////////////////////////////////////////

	// One class per opcode nibble; every field value outside its set is illegal
	always_comb begin
		d        = '0;
		d.opcode = w[23:16];
		d.cls    = w[23:20];
		d.size   = SZ_WORD;
		if (st_q == ST_ADDR_LO) begin
			d.cls     = CLS_PROG;
			d.opcode  = hi_op_q;
			d.lit     = {1'b0, hi_q, w[15:0]};
			// Second word must carry a zero opcode and an even address
			d.illegal = (w[23:16] != 8'h00) | w[0];
		end else begin
			case (w[23:20])
				CLS_FILE: begin
					d.size  = w[19:18];
					d.faddr = w[12:0];
					d.dst_w = ~w[13];
					d.dst   = REG_W0;
				end
				CLS_BIT: begin
					d.bpos    = w[15:12];
					d.src     = w[3:0];
					d.src_m   = w[6:4];
					d.illegal = ~odec_mode_ok(w[6:4]);
				end
				CLS_LIT10: begin
					d.size    = w[19:18];
					d.dst     = w[3:0];
					d.lit     = odec_ext({6'h00, w[13:4]}, 5'd10, 1'b0);
					// Byte size narrows the legal range to one byte
					d.illegal = (w[19:18] == SZ_BYTE) && (w[13:4] > 10'(BYTE_MAX));
				end
				CLS_DEFAULT_WORKING_REG: begin
					d.size    = w[19:18];
					d.base    = w[17:14];
					d.dst_m   = w[13:11];
					d.dst     = w[10:7];
					d.src_m   = w[6:4];
					d.src     = w[3:0];
					d.illegal = ~odec_mode_ok(w[13:11]) | ~odec_mode_ok(w[6:4]);
				end
				CLS_MAC, CLS_SQR: begin
					d.acc  = w[19];
					d.result_writeback_target  = w[3:2];
					d.xen  = xif.en;
					d.xptr = xif.ptr;
					d.xadj = xif.adj;
					d.xidx = xif.idx;
					d.yen  = yif.en;
					d.yptr = yif.ptr;
					d.yadj = yif.adj;
					d.yidx = yif.idx;
					d.xdst = REG_W4 + {2'h0, w[7:6]};
					d.ydst = REG_W4 + {2'h0, w[5:4]};
					if (w[23:20] == CLS_SQR) begin
						d.ma      = REG_W4 + {2'h0, pair[1:0]};
						d.mb      = REG_W4 + {2'h0, pair[1:0]};
						d.illegal = pair[2];
					end else begin
						// Six distinct pairs; the last two codes have no pair
						case (pair)
							3'h0: {d.ma, d.mb} = {4'h4, 4'h5};
							3'h1: {d.ma, d.mb} = {4'h4, 4'h6};
							3'h2: {d.ma, d.mb} = {4'h4, 4'h7};
							3'h3: {d.ma, d.mb} = {4'h5, 4'h6};
							3'h4: {d.ma, d.mb} = {4'h5, 4'h7};
							3'h5: {d.ma, d.mb} = {4'h6, 4'h7};
							default: d.illegal = 1'b1;
						endcase
					end
					if (w[3:2] != AWB_NONE) begin
						d.dst   = REG_W13;
						d.dst_m = (w[3:2] == AWB_POST) ? M_PINC : M_DIR;
					end
					if (w[3:2] > AWB_POST) begin
						d.illegal = 1'b1;
					end
				end
				CLS_LITK: begin
					case (w[19:16])
						4'h0: d.lit = odec_ext(w[15:0], 5'd1, 1'b0);
						4'h1: d.lit = odec_ext(w[15:0], 5'd4, 1'b0);
						4'h2: d.lit = odec_ext(w[15:0], 5'd5, 1'b0);
						4'h3: d.lit = odec_ext(w[15:0], 5'd8, 1'b0);
						4'h4: d.lit = odec_ext(w[15:0], 5'd14, 1'b0);
						4'h5: d.lit = odec_ext(w[15:0], 5'd16, 1'b0);
						4'h6: d.lit = odec_ext(w[15:0], 5'd6, 1'b1);
						4'h7: d.lit = odec_ext(w[15:0], 5'd10, 1'b1);
						4'h8: d.lit = odec_ext(w[15:0], 5'd16, 1'b1);
						default: d.illegal = 1'b1;
					endcase
				end
				CLS_DIV: begin
					d.src     = w[7:4];
					d.base    = w[3:0];
					// No room for modes: any bit above the pair is illegal
					d.illegal = (w[19:8] != 12'h000);
				end
				CLS_DSRC: begin
					d.acc     = w[19];
					d.src_m   = w[18:16];
					d.src     = w[15:12];
					d.base    = w[11:8];
					d.lit     = odec_ext({10'h000, w[5:0]}, 5'd6, 1'b1);
					d.illegal = (w[18:16] > M_OFFS);
				end
				default: d.illegal = 1'b1;
			endcase
			if (d.size == SZ_BAD) begin
				d.illegal = 1'b1;
			end
		end
	end

	// Decoded word register; squash mode hides illegal words from execute
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_valid_q <= 1'b0;
			dec_q       <= '0;
		end else begin
			dec_valid_q <= issue & ~(d.illegal & ctrl_q[CTRL_SQ]);
			if (issue) begin
				dec_q <= d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status bits and counters
	////////////////////////////////////////////////////////////////////////

	// Software writes first, datapath updates override per bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= '0;
		end else begin
			for (int i = 0; i < FLAG_W; i++) begin
				if (flag_we[i]) begin
					flags_q[i] <= flag_wd[i];
				end else if (wr_fire && paddr == OFS_FLAGS) begin
					flags_q[i] <= pwdata[i];
				end
			end
		end
	end

	// Sticky illegal seen; a new event beats a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ill_seen_q <= 1'b0;
		end else if (issue && d.illegal) begin
			ill_seen_q <= 1'b1;
		end else if (wr_fire && paddr == OFS_STAT && pwdata[STAT_ILL]) begin
			ill_seen_q <= 1'b0;
		end
	end

	// Decoded word counter, wraps silently
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else if (issue) begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave, one wait state
	////////////////////////////////////////////////////////////////////////

	assign wr_fire = psel & penable & ready_q & pwrite & ~err_q;

	// Read mux and decode of the mapped words
	always_comb begin
		hit = 1'b1;
		rd  = 32'h0000_0000;
		case (paddr)
			OFS_CTRL:  rd = {30'h0000_0000, ctrl_q};
			OFS_STAT:  rd = {16'h0000, dec_q.opcode, 7'h00, ill_seen_q};
			OFS_COUNT: rd = 32'(cnt_q);
			OFS_FLAGS: rd = {23'h00_0000, flags_q};
			default:   hit = 1'b0;
		endcase
	end

	// Control register steers decode enable and squash
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RST;
		end else if (wr_fire && paddr == OFS_CTRL) begin
			ctrl_q <= pwdata[1:0];
		end
	end

	// Registered answer keeps every bus output on a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_q <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else if (psel && penable && !ready_q) begin
			ready_q <= 1'b1;
			err_q   <= ~hit;
			rdata_q <= pwrite ? 32'h0000_0000 : rd;
		end else begin
			ready_q <= 1'b0;
			err_q   <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	////////////////////////////////////////////////////////////////////////

	assign prdata       = rdata_q;
	assign pready       = ready_q;
	assign pslverr      = err_q;
	assign status_flags = flags_q;
	assign dec_valid    = dec_valid_q;
	assign dec_illegal  = dec_q.illegal;
	assign dec_opcode   = dec_q.opcode;
	assign dec_class    = dec_q.cls;
	assign dec_size     = dec_q.size;
	assign acc_sel      = dec_q.acc;
	assign awb_sel      = dec_q.result_writeback_target;
	assign base_reg     = dec_q.base;
	assign src_reg      = dec_q.src;
	assign src_mode     = dec_q.src_m;
	assign dst_reg      = dec_q.dst;
	assign dst_mode     = dec_q.dst_m;
	assign dst_default_working_reg     = dec_q.dst_w;
	assign file_addr    = dec_q.faddr;
	assign bit_pos      = dec_q.bpos;
	assign lit_value    = dec_q.lit;
	assign mul_a        = dec_q.ma;
	assign mul_b        = dec_q.mb;
	assign x_en         = dec_q.xen;
	assign x_ptr        = dec_q.xptr;
	assign x_adj        = dec_q.xadj;
	assign x_idx        = dec_q.xidx;
	assign x_dst        = dec_q.xdst;
	assign y_en         = dec_q.yen;
	assign y_ptr        = dec_q.yptr;
	assign y_adj        = dec_q.yadj;
	assign y_idx        = dec_q.yidx;
	assign y_dst        = dec_q.ydst;
endmodule // odec_core
`default_nettype wire

//--- odec_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module odec_core_sva
	import odec_pkg::*;
(
	input wire logic              pclk,        // Clock
	input wire logic              presetn,     // Reset
	input wire logic              psel,        // Select
	input wire logic              penable,     // Access
	input wire logic              pready,      // Ready
	input wire logic              insn_valid,  // Word valid
	input wire logic [INSN_W-1:0] insn_word,   // Word
	input wire logic              dec_valid,   // Decoded
	input wire logic              dec_illegal, // Illegal
	input wire logic [OPC_W-1:0]  dec_opcode,  // Opcode
	input wire logic [3:0]        dec_class,   // Class
	input wire logic [1:0]        dec_size,    // Size
	input wire logic [1:0]        awb_sel,     // Write-back
	input wire logic [3:0]        dst_reg,     // Dest reg
	input wire logic [2:0]        dst_mode,    // Dest mode
	input wire logic              dst_default_working_reg,    // To W0
	input wire logic [LIT_W-1:0]  lit_value,   // Literal
	input wire logic [3:0]        mul_a,       // Factor a
	input wire logic [3:0]        mul_b,       // Factor b
	input wire logic [3:0]        x_dst,       // X target
	input wire logic [3:0]        y_dst        // Y target
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////
	// Decode timing and opcode, one cycle after the word
	property p_dv; dec_valid |-> $past(insn_valid); endproperty
	a_dv: assert property (p_dv) else $error("decode without word");
	property p_opc; dec_valid && dec_class != CLS_PROG |-> dec_opcode == $past(insn_word[23:16]); endproperty
	a_opc: assert property (p_opc) else $error("opcode not leading byte");
	// Operand sets of legal words
	property p_sqr; dec_valid && dec_class == CLS_SQR && !dec_illegal |-> mul_a == mul_b && mul_a[3:2] == 2'b01;
	endproperty
	a_sqr: assert property (p_sqr) else $error("bad square pair");
	property p_mac; dec_valid && dec_class == CLS_MAC && !dec_illegal |-> mul_a < mul_b && mul_a[3:2] == 2'b01
		&& mul_b[3:2] == 2'b01; endproperty
	a_mac: assert property (p_mac) else $error("bad multiply pair");
	property p_pfd; dec_valid && (dec_class == CLS_MAC || dec_class == CLS_SQR) |-> x_dst[3:2] == 2'b01
		&& y_dst[3:2] == 2'b01; endproperty
	a_pfd: assert property (p_pfd) else $error("prefetch target out of W4..W7");
	property p_awb; dec_valid && (dec_class == CLS_MAC || dec_class == CLS_SQR) && awb_sel == AWB_POST
		|-> dst_reg == REG_W13 && dst_mode == M_PINC; endproperty
	a_awb: assert property (p_awb) else $error("write-back not W13 post-increment");
	property p_default_working_reg; dec_valid && dec_class == CLS_FILE && dst_default_working_reg |-> dst_reg == REG_W0; endproperty
	a_default_working_reg: assert property (p_default_working_reg) else $error("default result not W0");
	property p_size; dec_valid && !dec_illegal |-> dec_size != SZ_BAD; endproperty
	a_size: assert property (p_size) else $error("bad size accepted");
	property p_l10; dec_valid && dec_class == CLS_LIT10 && dec_size == SZ_BYTE && !dec_illegal
		|-> lit_value <= 24'h00_00ff; endproperty
	a_l10: assert property (p_l10) else $error("byte literal above 255");
	property p_prg; dec_valid && dec_class == CLS_PROG && !dec_illegal |-> !lit_value[0] && !lit_value[23];
	endproperty
	a_prg: assert property (p_prg) else $error("odd program address accepted");
	// Bus: one wait state, ready one cycle only
	property p_ws; psel && penable && !pready |=> pready ##1 !pready; endproperty
	a_ws: assert property (p_ws) else $error("ready timing wrong");
endmodule // odec_core_sva
bind odec_core odec_core_sva u_sva (.*);
`default_nettype wire

//--- odec_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module odec_fetch_model
	import odec_pkg::*;
(
	input  wire logic              pclk,       // Clock
	output logic                   insn_valid, // Word valid
	output logic [INSN_W-1:0]      insn_word,  // Word
	output logic [FLAG_W-1:0]      flag_we,    // Flag enables
	output logic [FLAG_W-1:0]      flag_wd     // Flag values
);
	// Quiet at time zero
	initial begin
		insn_valid = 1'b0;
		insn_word  = '0;
		flag_we    = '0;
		flag_wd    = '0;
	end
	// One 24-bit word per call; the stale word is inverted so nothing leans on it
	task automatic send(input logic [INSN_W-1:0] w);
		@(posedge pclk);
		insn_valid <= 1'b1;
		insn_word  <= w;
		@(posedge pclk);
		insn_valid <= 1'b0;
		insn_word  <= ~w;
		#1;
	endtask
	// Datapath flag update for one cycle
	task automatic flag(input logic [FLAG_W-1:0] we, input logic [FLAG_W-1:0] wd);
		@(posedge pclk);
		flag_we <= we;
		flag_wd <= wd;
		@(posedge pclk);
		flag_we <= '0;
		#1;
	endtask
endmodule // odec_fetch_model
`default_nettype wire

//--- odec_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
module odec_core_bench;
	import odec_pkg::*;
	logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [7:0]        paddr = '0, dec_opcode;
	logic [31:0]       pwdata = '0, prdata, rd;
	logic              pready, pslverr, dec_valid, dec_illegal, acc_sel, dst_default_working_reg, x_en, x_idx, y_en, y_idx;
	logic              insn_valid;
	logic [INSN_W-1:0] insn_word;
	logic [FLAG_W-1:0] flag_we, flag_wd, status_flags;
	logic [3:0]        base_reg, src_reg, dst_reg, mul_a, mul_b, x_ptr, y_ptr, x_dst, y_dst, bit_pos, dec_class;
	logic signed [3:0] x_adj, y_adj;
	logic [2:0]        src_mode, dst_mode;
	logic [1:0]        dec_size, awb_sel;
	logic [12:0]       file_addr;
	logic [LIT_W-1:0]  lit_value;
	logic [3:0]        adj [7] = '{4'h6, 4'h4, 4'h2, 4'h0, 4'ha, 4'hc, 4'he};
	logic [7:0]        mp [6] = '{8'h45, 8'h46, 8'h47, 8'h56, 8'h57, 8'h67};
	int                lw [9] = '{1, 4, 5, 8, 14, 16, 6, 10, 16};
	int                fail_count = 0, tests_run = 0, cyc = 0;
	always #4 pclk = ~pclk;
	odec_fetch_model u_fm (.*);
	odec_core u_dut (.*);
	////////////////////////////////////////////////////////////
	// Hang guard, far above the couple of hundred cycles used
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			conclude();
		end
	end
	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Bus cycle held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
		#1;
	endtask
	task automatic sd(input logic [23:0] w, input logic il);
		u_fm.send(w);
		ck(dec_valid, 1);
		ck(dec_illegal, il);
	endtask
	////////////////////////////////////////////////////////////
	task automatic s_regs;
		apb(0, OFS_CTRL, 0);
		ck(rd, 1);
		apb(0, 8'h10, 0);
		ck({er, rd[30:0]}, 32'h8000_0000);
		apb(1, OFS_FLAGS, 32'h0000_01ff);
		ck(status_flags, 9'h1ff);
		u_fm.flag(9'h001, 9'h000);
		apb(0, OFS_FLAGS, 0);
		ck(rd, 32'h0000_01fe);
	endtask
	// Multiply, square and prefetch field sets, all codes
	task automatic s_dsp;
		for (int p = 0; p < 8; p++) begin
			sd({4'h5, p[0], p[2:0], 8'hff, p[1:0], ~p[1:0], 2'(p % 3), 2'b00}, p > 5);
			if (p < 6) ck({mul_a, mul_b}, mp[p]);
			ck({acc_sel, awb_sel, x_dst, y_dst}, {p[0], 2'(p % 3), 4'(4 + p % 4), 4'(7 - p % 4)});
			sd({4'h6, 1'b0, p[2:0], 8'hff, 8'h08}, p > 3);
			if (p < 4) ck({mul_a, mul_b, dst_reg, dst_mode}, {8'(p * 17 + 68), REG_W13, M_PINC});
		end
		for (int c = 0; c < 16; c++) begin
			sd({8'h50, c[3:0], c[3:0], 8'h00}, 0);
			ck({x_en, y_en}, {2{c < 15}});
			if (c < 15) ck({x_ptr, x_idx, y_ptr, y_idx}, {4'(8 + (c > 6)), c == 14, 4'(10 + (c > 6)), c == 14});
			if (c < 14) ck({x_adj, y_adj}, {2{adj[c % 7]}});
		end
	endtask
	// Literal widths and extension, byte limit of the 10-bit field
	task automatic s_lit;
		for (int k = 0; k < 10; k++) begin
			sd({4'h7, k[3:0], 16'hffff}, k > 8);
			if (k < 9) ck(lit_value, k < 6 ? (1 << lw[k]) - 1 : 24'hff_ffff);
		end
		sd({8'h34, 2'b00, 10'h0ff, 4'h1}, 0);
		ck(lit_value, 255);
		sd({8'h34, 2'b00, 10'h100, 4'h1}, 1);
		sd({8'h30, 2'b00, 10'h3ff, 4'h1}, 0);
		ck(lit_value, 1023);
		sd({8'h3c, 2'b00, 10'h3ff, 4'h1}, 1);
	endtask
	// Register fields, file, divide, program address, squash
	task automatic s_misc;
		sd({4'h1, 2'd0, 4'd0, 1'b0, 13'h1fff}, 0);
		ck({dec_class, dst_default_working_reg, dst_reg, file_addr, dec_size}, {CLS_FILE, 1'b1, REG_W0, 13'h1fff, SZ_WORD});
		sd({8'h20, 4'hf, 5'h0, M_PINC, 4'h7}, 0);
		ck({bit_pos, src_reg, src_mode}, {8'hf7, M_PINC});
		sd({4'h4, 2'd0, 4'd3, 3'd2, 4'd15, 3'd6, 4'd9}, 1);
		ck({base_reg, dst_reg, src_reg}, 12'h3f9);
		sd({20'h9_0002, 4'h5}, 0);
		ck({src_reg, base_reg}, 8'h25);
		sd({20'h9_0012, 4'h5}, 1);
		sd({4'ha, 1'b1, 3'd6, 16'h3200}, 0);
		ck({acc_sel, src_mode, src_reg, base_reg}, {1'b1, M_OFFS, 8'h32});
		sd({4'ha, 1'b0, 3'd7, 16'h3200}, 1);
		u_fm.send(24'h80_007f);
		ck(dec_valid, 0);
		sd(24'h00_fffe, 0);
		ck({dec_opcode, lit_value}, 32'h807f_fffe);
		u_fm.send(24'h80_007f);
		sd(24'h00_0001, 1);
		apb(0, OFS_STAT, 0);
		ck(rd[0], 1);
		apb(1, OFS_CTRL, 3);
		u_fm.send(24'h00_0000);
		ck(dec_valid, 0);
		apb(1, OFS_CTRL, 1);
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		s_regs();
		s_dsp();
		s_lit();
		s_misc();
		conclude();
	end
endmodule // odec_core_bench
`default_nettype wire
